/* File: verilog/qcsio_top.sv */
// Quadrature counters and special input/output allocation
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps

module qcsio_top
  import qcsio_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Digital input pins
  input wire logic [15:0] din,
  // Per-pin role outputs toward other engines
  output logic [5:0] pulse_measure_input,
  output logic [15:0] irq_input,
  output logic [15:0] plain_input,
  output logic [2:0] match_event,
  // Special output sources and pins
  input wire qcsio_spout_t spout,
  output logic [15:0] dout
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [15:0] sy1_r; // First stage, read by stage two only
  logic [15:0] sy2_r; // Second stage
  logic [15:0] sy3_r; // Third stage
  logic [15:0] pin_r; // Accepted level

  // Three stages; accept when two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
      pin_r <= '0;
    end else begin
      sy1_r <= din;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_r <= (sy2_r & sy3_r) | (pin_r & (sy2_r | sy3_r));
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [2:0] cnt_en_r; // Counter defined per channel
  logic [2:0] mode_r; // 0 simple, 1 enhanced
  logic [5:0] pm_en_r; // Pulse measure only enables
  logic [15:0] irq_en_r; // Interrupt role per input
  logic [7:0] outf_r; // Two bits per output five-eight
  logic [15:0] do_r; // Plain output levels
  logic [2:0] match_r; // Sticky match flags
  logic [31:0] tgt_r [QCSIO_NCH]; // Target counts
  logic signed [31:0] cnt_r [QCSIO_NCH]; // Channel counts

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire wr_acc = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite; // Read setup phase
  wire hit_ctrl = (paddr == QCSIO_CTRL);
  wire hit_mode = (paddr == QCSIO_MODE);
  wire hit_pmen = (paddr == QCSIO_PMEN);
  wire hit_irq = (paddr == QCSIO_IRQEN);
  wire hit_outf = (paddr == QCSIO_OUTF);
  wire hit_stat = (paddr == QCSIO_STAT);
  wire hit_pin = (paddr == QCSIO_PIN);
  wire hit_do = (paddr == QCSIO_DO);
  logic [2:0] hit_tgt; // Target word hits
  logic [2:0] hit_cnt; // Count word hits
  wire hit_any = hit_ctrl | hit_mode | hit_pmen | hit_irq | hit_outf |
                 hit_stat | hit_pin | hit_do | (|hit_tgt) | (|hit_cnt);

  // Zero wait state; error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // Counter enable masked by interrupt role on either phase
  logic [2:0] cnt_live; // Channel actually counting
  logic [2:0] fire; // Count meets target this cycle
  logic [2:0] pm_from_cnt; // Measure enabled by definition

  genvar g;
  generate
    for (g = 0; g < QCSIO_NCH; g++) begin : g_ch
      localparam logic [11:0] OFS = 12'(g) * QCSIO_REG_STRIDE;
      assign hit_tgt[g] = (paddr == QCSIO_TGT0 + OFS);
      assign hit_cnt[g] = (paddr == QCSIO_CNT0 + OFS);
      // Phase A odd input, B even input
      qcsio_phase_t ph;
      assign ph.a = pin_r[2*g];
      assign ph.b = pin_r[2*g+1];
      assign cnt_live[g] = cnt_en_r[g] & ~irq_en_r[2*g] &
                           ~irq_en_r[2*g+1];
      assign pm_from_cnt[g] = cnt_en_r[g];

      // Previous phase levels
      logic pa_r;
      logic pb_r;
      qcsio_qstate_t st_r;
      qcsio_qstate_t st_nxt;
      logic last_dir_r; // Last enhanced step, 1 up
      logic lock_r; // Last step not yet re-armed
      wire a_rise = ph.a & ~pa_r;
      wire b_rise = ph.b & ~pb_r;

      // Simple: each rising edge counted alone
      // A rise with B off or B lagging counts up
      wire s_up = a_rise & ~ph.b;
      // B rise with A off counts down
      wire s_dn = b_rise & ~ph.a;

      // Enhanced: full state walk, step only at A rise/B rise pair
      always_comb begin
        case ({ph.a, ph.b})
          2'b00: st_nxt = QCSIO_S00;
          2'b10: st_nxt = QCSIO_S10;
          2'b11: st_nxt = QCSIO_S11;
          2'b01: st_nxt = QCSIO_S01;
          default: st_nxt = QCSIO_S00;
        endcase
      end
      // Count one per cycle at the rising edge of A (up) or B (down)
      wire e_up_raw = (st_r == QCSIO_S00) & (st_nxt == QCSIO_S10);
      wire e_dn_raw = (st_r == QCSIO_S00) & (st_nxt == QCSIO_S01);
      // Same direction again while still locked is jiggle
      wire e_up = e_up_raw & ~(lock_r & last_dir_r);
      wire e_dn = e_dn_raw & ~(lock_r & ~last_dir_r);
      // Re-arm once the other phase moves
      wire rearm = last_dir_r ? (ph.b != pb_r) : (ph.a != pa_r);

      wire up = mode_r[g] ? e_up : s_up;
      wire dn = mode_r[g] ? e_dn : s_dn;
      assign fire[g] = cnt_live[g] & (cnt_r[g] == $signed(tgt_r[g]));

      // Decoder history
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          pa_r <= 1'b0;
          pb_r <= 1'b0;
          st_r <= QCSIO_S00;
          last_dir_r <= 1'b0;
          lock_r <= 1'b0;
        end else begin
          pa_r <= ph.a;
          pb_r <= ph.b;
          st_r <= st_nxt;
          if (~mode_r[g]) begin
            // Simple mode keeps no lock history
            last_dir_r <= 1'b0;
            lock_r <= 1'b0;
          end else if (e_up_raw | e_dn_raw) begin
            last_dir_r <= e_up_raw;
            lock_r <= 1'b1;
          end else if (rearm) begin
            lock_r <= 1'b0;
          end
        end
      end

      // Count and target registers
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          cnt_r[g] <= '0;
          tgt_r[g] <= QCSIO_RST;
        end else begin
          if (wr_acc & hit_tgt[g])
            tgt_r[g] <= pwdata;
          if (wr_acc & hit_cnt[g])
            cnt_r[g] <= pwdata;
          else if (cnt_live[g] & up & ~dn)
            cnt_r[g] <= cnt_r[g] + 32'sh1;
          else if (cnt_live[g] & dn & ~up)
            cnt_r[g] <= cnt_r[g] - 32'sh1;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Match event: one pulse on reaching target
  // ------------------------------------------------------------
  logic [2:0] fire_d_r; // Previous compare result

  always_ff @(posedge sys_clk) begin
    if (reset)
      fire_d_r <= '0;
    else
      fire_d_r <= fire;
  end
  assign match_event = fire & ~fire_d_r;

  // ------------------------------------------------------------
  // Control register writes
  // ------------------------------------------------------------
  // Defining a counter leaves a measure-only enable set;
  // enabling measure afterwards drops the counter
  wire [2:0] pm_pair_wr = {|pwdata[5:4], |pwdata[3:2], |pwdata[1:0]};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_en_r <= '0;
      mode_r <= '0;
      pm_en_r <= '0;
      irq_en_r <= '0;
      outf_r <= '0;
      do_r <= '0;
    end else begin
      if (wr_acc & hit_ctrl)
        cnt_en_r <= pwdata[2:0];
      else if (wr_acc & hit_pmen)
        cnt_en_r <= cnt_en_r & ~pm_pair_wr;
      if (wr_acc & hit_mode)
        mode_r <= pwdata[2:0];
      if (wr_acc & hit_pmen)
        pm_en_r <= pwdata[5:0];
      if (wr_acc & hit_irq)
        irq_en_r <= pwdata[15:0] & QCSIO_IRQ_CAPABLE;
      if (wr_acc & hit_outf)
        outf_r <= pwdata[7:0];
      if (wr_acc & hit_do)
        do_r <= pwdata[15:0];
    end
  end

  // Sticky match flags; set wins over write-one clear
  always_ff @(posedge sys_clk) begin
    if (reset)
      match_r <= '0;
    else
      match_r <= match_event |
                 (match_r & ~(wr_acc & hit_stat ? pwdata[2:0] : 3'h0));
  end

  // ------------------------------------------------------------
  // Input role allocation
  // ------------------------------------------------------------
  wire [5:0] cnt_pins = {{2{cnt_live[2]}}, {2{cnt_live[1]}},
                         {2{cnt_live[0]}}};
  wire [5:0] pm_on = ({{2{pm_from_cnt[2]}}, {2{pm_from_cnt[1]}},
                       {2{pm_from_cnt[0]}}} | pm_en_r) &
                     ~irq_en_r[5:0];
  // Measure sees pin n on channel n, alongside counting
  assign pulse_measure_input = pin_r[5:0] & pm_on;
  assign irq_input = pin_r & irq_en_r;
  // Pins with no special role read as plain inputs
  assign plain_input = pin_r & ~irq_en_r &
                       ~{10'h000, pm_on | cnt_pins};

  // ------------------------------------------------------------
  // Output role allocation: outputs five-eight
  // ------------------------------------------------------------
  logic [3:0] spo; // Special drive for outputs five-eight
  logic [3:0] spo_sel; // Output has special role

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // One role per output
      case (outf_r[2*i +: 2])
        QCSIO_OF_PLAIN: begin
          spo[i] = do_r[4+i];
          spo_sel[i] = 1'b0;
        end
        QCSIO_OF_PWM: begin
          spo[i] = spout.pwm[i];
          spo_sel[i] = 1'b1;
        end
        // Order: dir1, pulse1, dir2, pulse2
        QCSIO_OF_STEP_PD: begin
          spo[i] = spout.step_pd[i];
          spo_sel[i] = 1'b1;
        end
        QCSIO_OF_STEP_PH: begin
          spo[i] = spout.step_ph[i];
          spo_sel[i] = 1'b1;
        end
        default: begin
          spo[i] = do_r[4+i];
          spo_sel[i] = 1'b0;
        end
      endcase
    end
  end

  // Registered pin outputs; unused roles are plain
  always_ff @(posedge sys_clk) begin
    if (reset)
      dout <= '0;
    else
      dout <= {do_r[15:8], spo, do_r[3:0]};
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  logic [31:0] rd_mux; // Word selected by paddr

  // Word selection by address
  always_comb begin
    rd_mux = QCSIO_ERR_DATA;
    if (hit_ctrl) rd_mux = {29'h0, cnt_en_r};
    if (hit_mode) rd_mux = {29'h0, mode_r};
    if (hit_pmen) rd_mux = {26'h0, pm_on};
    if (hit_irq) rd_mux = {16'h0, irq_en_r};
    if (hit_outf) rd_mux = {20'h0, spo_sel, outf_r};
    if (hit_stat) rd_mux = {29'h0, match_r};
    if (hit_pin) rd_mux = {16'h0, pin_r};
    if (hit_do) rd_mux = {16'h0, do_r};
    for (int k = 0; k < QCSIO_NCH; k++) begin
      if (hit_tgt[k]) rd_mux = tgt_r[k];
      if (hit_cnt[k]) rd_mux = cnt_r[k];
    end
  end

  // Captured in setup so the word stands from a flop in access
  always_ff @(posedge sys_clk) begin
    if (reset)
      prdata <= QCSIO_RST;
    else if (rd_setup)
      prdata <= rd_mux;
    else
      prdata <= QCSIO_ERR_DATA; // Zero outside a read
  end

endmodule // qcsio_top

/* File: verilog/qcsio_pkg.sv */
// Package: constants and types for the quadrature counter special I/O block
package qcsio_pkg;
  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] QCSIO_CTRL = 12'h000; // Counter enables
  localparam logic [11:0] QCSIO_MODE = 12'h004; // Counting method select
  localparam logic [11:0] QCSIO_PMEN = 12'h008; // Pulse measure enables
  localparam logic [11:0] QCSIO_IRQEN = 12'h00c; // Interrupt pin roles
  localparam logic [11:0] QCSIO_OUTF = 12'h010; // Output role select
  localparam logic [11:0] QCSIO_STAT = 12'h014; // Match flags, w1c
  localparam logic [11:0] QCSIO_PIN = 12'h018; // Pin levels
  localparam logic [11:0] QCSIO_TGT0 = 12'h020; // Target ch1..3 at +4
  localparam logic [11:0] QCSIO_CNT0 = 12'h030; // Count ch1..3 at +4
  localparam logic [11:0] QCSIO_REG_STRIDE = 12'h004; // Word stride
  localparam logic [11:0] QCSIO_DO = 12'h040; // Plain output levels
  // ------------------------------------------------------------
  // Sizes and field layout
  // ------------------------------------------------------------
  localparam int QCSIO_NCH = 3; // Counter channels
  localparam int QCSIO_NIN = 16; // Digital inputs
  localparam int QCSIO_NSPIN = 6; // Shared counter inputs
  localparam int QCSIO_CW = 32; // Count width
  localparam logic [1:0] QCSIO_OF_PLAIN = 2'h0; // Output role: plain
  localparam logic [1:0] QCSIO_OF_PWM = 2'h1; // Output role: PWM
  localparam logic [1:0] QCSIO_OF_STEP_PD = 2'h2; // Stepper pulse/dir
  localparam logic [1:0] QCSIO_OF_STEP_PH = 2'h3; // Stepper phases
  localparam logic [15:0] QCSIO_IRQ_CAPABLE = 16'h0f3f; // Inputs 1-6, 9-12
  localparam logic [31:0] QCSIO_RST = 32'h0000_0000; // Register reset
  localparam logic [31:0] QCSIO_ERR_DATA = 32'h0000_0000; // Unmapped read

  // Decoder state: one-hot per phase pair
  typedef enum logic [3:0] {
    QCSIO_S00 = 4'h1,
    QCSIO_S01 = 4'h2,
    QCSIO_S11 = 4'h4,
    QCSIO_S10 = 4'h8
  } qcsio_qstate_t;

  // Phase pair for one channel
  typedef struct packed {
    logic a;
    logic b;
  } qcsio_phase_t;

  // Special output drive from other engines
  typedef struct packed {
    logic [3:0] pwm;
    logic [3:0] step_pd;
    logic [3:0] step_ph;
  } qcsio_spout_t;
endpackage

/* File: bench/qcsio_top_properties.sv */
// Port assertions for the quadrature counter special I/O block
`timescale 1ns/1ps
module qcsio_top_properties
  import qcsio_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin roles and events
  input wire logic [5:0] pulse_measure_input,
  input wire logic [15:0] irq_input,
  input wire logic [15:0] plain_input,
  input wire logic [2:0] match_event,
  input wire logic [15:0] dout
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_err_read_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  a_irq_capable: assert property ((irq_input & ~16'h0f3f) == 16'h0)
    else $error("interrupt role on incapable input");
  a_irq_not_plain: assert property ((irq_input & plain_input) == 0)
    else $error("interrupt pin also plain");
  a_irq_not_pm: assert property
    ((irq_input[5:0] & pulse_measure_input) == 6'h0)
    else $error("interrupt pin still measured");
  a_pm_not_plain: assert property
    ((pulse_measure_input & plain_input[5:0]) == 6'h0)
    else $error("measured pin also plain");
  a_match_one_shot: assert property (match_event != 3'h0 |=>
    (match_event & $past(match_event)) == 3'h0)
    else $error("match event longer than a cycle");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |=> match_event == 3'h0 && dout == 16'h0)
    else $error("outputs not cleared by reset");
endmodule // qcsio_top_properties

bind qcsio_top qcsio_top_properties chk_i (.sys_clk, .reset, .psel,
  .penable, .prdata, .pready, .pslverr, .pulse_measure_input,
  .irq_input, .plain_input, .match_event, .dout);

/* File: bench/qcsio_encoder.sv */
// Quadrature encoder model driving one phase pair
`timescale 1ns/1ps
module qcsio_encoder
  import qcsio_pkg::*;
#(
  parameter int HOLD = 6 // Cycles each level stands, scaled rate
)
(
  // Clock
  input wire logic sys_clk,
  // Phase pair
  output qcsio_phase_t ph
);
  initial ph = '0;
  // Set both phases after an edge, then hold them
  task automatic put(input logic pa, input logic pb);
    ph <= '{a: pa, b: pb};
    repeat (HOLD) @(posedge sys_clk);
  endtask
  // Full quadrature cycles, A leading when up
  task automatic turn(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      put(up, !up);
      put(1'b1, 1'b1);
      put(!up, up);
      put(1'b0, 1'b0);
    end
  endtask
  // Pulses on one phase, other held off
  task automatic pulse(input bit onb, input int n);
    for (int i = 0; i < n; i++) begin
      put(!onb, onb);
      put(1'b0, 1'b0);
    end
  endtask
endmodule // qcsio_encoder

/* File: bench/qcsio_top_tb.sv */
// Self-checking testbench for the quadrature counter block
`timescale 1ns/1ps
module qcsio_top_tb;
  import qcsio_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] din, din_o, irq_input, plain_input, dout;
  logic [5:0] pulse_measure_input;
  logic [2:0] match_event;
  qcsio_spout_t spout;
  qcsio_phase_t ph;
  int fails, n_compared, hits, ch_sel;
  // Encoder pair lands on the chosen channel's inputs
  assign din = din_o | ({14'h0, ph.b, ph.a} << (2 * ch_sel));
  qcsio_top dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .din, .pulse_measure_input,
    .irq_input, .plain_input, .match_event, .spout, .dout);
  qcsio_encoder enc (.sys_clk, .ph);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Channel one match pulses
  always @(posedge sys_clk)
    hits <= reset ? 0 : hits + int'(match_event[0]);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i <= 16; i++)
      rdc(12'(4 * i), 32'h0, "reset word");
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
  endtask
  task automatic t_quad;
    apb(1'b1, QCSIO_CTRL, 32'h7);
    for (int c = 0; c < 3; c++) begin
      ch_sel <= c;
      enc.turn(3, 1'b1);
      enc.turn(1, 1'b0);
      rdc(QCSIO_CNT0 + 12'(4 * c), 32'h2, "fwd");
      enc.turn(4, 1'b0);
      rdc(QCSIO_CNT0 + 12'(4 * c), 32'hffff_fffe, "rev");
    end
    // Enhanced mode must still count every full turn both ways
    apb(1'b1, QCSIO_MODE, 32'h7);
    for (int c = 0; c < 3; c++) begin
      ch_sel <= c;
      enc.turn(3, 1'b1);
      rdc(QCSIO_CNT0 + 12'(4 * c), 32'h1, "enh fwd");
      enc.turn(2, 1'b0);
      rdc(QCSIO_CNT0 + 12'(4 * c), 32'hffff_ffff, "enh rev");
    end
  endtask
  task automatic t_mode;
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      apb(1'b1, QCSIO_MODE, {29'h0, m});
      apb(1'b1, QCSIO_CTRL, 32'(1 << (i % 3)));
      apb(1'b1, QCSIO_CNT0 + 12'(4 * (i % 3)), 32'h0);
      ch_sel <= i % 3;
      enc.pulse(1'b0, 3);
      rdc(QCSIO_CNT0 + 12'(4 * (i % 3)), m[i % 3] ? 1 : 3,
          "jig");
    end
  endtask
  task automatic t_single;
    apb(1'b1, QCSIO_MODE, 32'h0);
    apb(1'b1, QCSIO_CTRL, 32'h1);
    apb(1'b1, QCSIO_CNT0, 32'h0);
    ch_sel <= 0;
    enc.pulse(1'b0, 3);
    rdc(QCSIO_CNT0, 32'h3, "a only");
    enc.pulse(1'b1, 2);
    rdc(QCSIO_CNT0, 32'h1, "b only");
    apb(1'b1, QCSIO_CTRL, 32'h0);
    enc.pulse(1'b0, 2);
    rdc(QCSIO_CNT0, 32'h1, "held");
  endtask
  task automatic t_match;
    int h0;
    apb(1'b1, QCSIO_CTRL, 32'h1);
    apb(1'b1, QCSIO_TGT0, 32'h2);
    apb(1'b1, QCSIO_CNT0, 32'h0);
    apb(1'b1, QCSIO_STAT, 32'h7);
    h0 = hits;
    enc.pulse(1'b0, 2);
    chk("match", 32'(hits - h0), 32'h1);
    rdc(QCSIO_STAT, 32'h1, "flag");
    apb(1'b1, QCSIO_STAT, 32'h1);
    rdc(QCSIO_STAT, 32'h0, "flag clr");
    apb(1'b1, QCSIO_TGT0, 32'h5);
    enc.pulse(1'b0, 4);
    chk("rematch", 32'(hits - h0), 32'h2);
  endtask
  task automatic t_roles;
    apb(1'b1, QCSIO_PMEN, 32'h1);
    rdc(QCSIO_CTRL, 32'h0, "late pm");
    apb(1'b1, QCSIO_CTRL, 32'h2);
    rdc(QCSIO_PMEN, 32'hd, "pm eff");
    din_o <= 16'hffff;
    repeat (5) @(posedge sys_clk);
    chk("pm pins", {26'h0, pulse_measure_input}, 32'hd);
    chk("plain", {16'h0, plain_input}, 32'hfff2);
    apb(1'b1, QCSIO_IRQEN, 32'hffff);
    rdc(QCSIO_IRQEN, 32'h0f3f, "irq mask");
    chk("irq", {16'h0, irq_input}, 32'h0f3f);
    chk("pm off", {26'h0, pulse_measure_input}, 32'h0);
    chk("plain rest", {16'h0, plain_input}, 32'hf0c0);
    apb(1'b1, QCSIO_IRQEN, 32'h0);
    din_o <= 16'h0;
  endtask
  task automatic t_outs;
    logic [3:0] nib[4];
    nib = '{4'hc, 4'ha, 4'h5, 4'h3};
    spout <= '{pwm: 4'ha, step_pd: 4'h5, step_ph: 4'h3};
    apb(1'b1, QCSIO_DO, 32'h12c4);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, QCSIO_OUTF, {24'h0, {4{2'(r)}}});
      repeat (3) @(posedge sys_clk);
      chk("dout", {16'h0, dout},
          {16'h0, 8'h12, nib[r], 4'h4});
      rdc(QCSIO_OUTF, {20'h0, {4{r != 0}}, {4{2'(r)}}}, "outf");
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    din_o = 16'h0;
    spout = '0;
    ch_sel = 0;
    fails = 0;
    n_compared = 0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_quad;
    t_mode;
    t_single;
    t_match;
    t_roles;
    t_outs;
    end_of_test;
  end
  initial begin
    #500000;
    fails++;
    end_of_test;
  end
endmodule // qcsio_top_tb
